// ### rtl/core_exec.sv
// execute block for table write, test-skip-zero and the two xor forms
// assumes an apb master on clk; instructions are issued by writing the instr register
//
// How it works
// (RULE_01) the table pointer is a 21-bit byte address covering 2 Mbyte.
// (RULE_02) pointer bit 0 picks the low byte (0) or high byte (1) of a program word; the code picks one of eight holding bytes by pointer bits 2:0.
// (RULE_03) post-increment table write stores the latch at the current pointer, then adds one.
// (RULE_04) pre-increment table write adds one first, then stores; other holding bytes keep.
// (RULE_05) test-skip-zero decodes from 0110 011a ffff ffff, a choosing the bank mode.
// (RULE_06) a zero tested register discards the next instruction, costing a second nop cycle.
// (RULE_07) if the skipped instruction is two words, the skip takes three cycles in all.
// (RULE_08) access bit 0 uses the access bank, access bit 1 uses the bank select register.
// (RULE_09) with the extension on and access bit 0, addresses up to 95 are index offsets.
// (RULE_10) literal xor decodes from 0000 1010 kkkk kkkk.
// (RULE_11) literal xor puts working register xor literal back into the working register.
// (RULE_12) file xor decodes from 0001 10da ffff ffff.
// (RULE_13) file xor reads the register in quarter two and writes in quarter four.
// (RULE_14) destination 0 writes the working register, 1 writes the file register.
// (RULE_15) only the xors touch flags, and only negative and zero.
// (RULE_16) negative copies result bit 7, zero is set when the result is all zero.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "core_exec_regs.svh"

module core_exec
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  output logic             busy
);

  core_exec_pkg::exec_regs_t s_r;
  core_exec_pkg::exec_regs_t s_nxt;

  // file registers kept outside the struct; only 256 bytes, upper address bits alias
  logic [7:0] dmem [0:255];
  logic       mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;

  logic [7:0] x_y;
  logic       x_neg;
  logic       x_zero;
  logic [7:0] x_b;

  logic is_xor_lit;
  logic is_xor_file;
  logic is_tst;
  logic is_table_write;
  logic setup;
  logic commit;
  logic bsy;

  assign is_xor_lit     = (s_r.op[15:8] == `OPC_XOR_LIT);      // RULE_10
  assign is_xor_file    = (s_r.op[15:10] == `OPC_XOR_FILE);    // RULE_12
  assign is_tst         = (s_r.op[15:9] == `OPC_TEST_SKIP);    // RULE_05
  assign is_table_write = (s_r.op[15:2] == `OPC_TABLE_WRITE);
  assign bsy            = (s_r.state != core_exec_pkg::ST_IDLE);
  assign setup          = psel & ~penable;
  assign commit         = psel & penable & s_r.pready & ~s_r.pslverr;
  assign x_b            = is_xor_lit ? s_r.op[7:0] : s_r.operand;

  xor_flag_unit u_xor
  (
    .a    (s_r.wreg),
    .b    (x_b),
    .y    (x_y),
    .neg  (x_neg),
    .zero (x_zero)
  );

  function automatic logic [11:0] file_addr(input logic [15:0] op,
                                            input logic [3:0] bank,
                                            input logic [11:0] base,
                                            input logic ext);
    logic [7:0] f;
    f = op[7:0];
    if (op[8])
      file_addr = {bank, f}; // RULE_08
    else if (ext && f <= `EXT_LIMIT)
      file_addr = base + {4'h0, f}; // RULE_09
    else if (f >= `ACC_SPLIT)
      file_addr = {`ACC_HIGH_BANK, f}; // RULE_08
    else
      file_addr = {`ACC_LOW_BANK, f};
  endfunction

  function automatic logic [31:0] rd_mux(input core_exec_pkg::exec_regs_t s,
                                         input logic [11:0] a,
                                         input logic b);
    rd_mux = 32'h0000_0000;
    if (a[11:10] == `DMEM_PAGE)
      rd_mux = {24'h00_0000, dmem[a[9:2]]};
    else if (a[11:5] == `HOLD_PAGE)
      rd_mux = {24'h00_0000, s.hold[a[4:2]]};
    else
      case (a)
        `REG_CTRL:    rd_mux = {30'h0000_0000, s.two_word, s.ext_en};
        `REG_INSTR:   rd_mux = {16'h0000, s.op};
        `REG_STATUS:  rd_mux = {28'h000_0000, s.skipped, s.zero, s.neg, b};
        `REG_WORK:    rd_mux = {24'h00_0000, s.wreg};
        `REG_TABLE_POINTER: rd_mux = {11'h000, s.table_pointer};
        `REG_TABLE_LATCH:   rd_mux = {24'h00_0000, s.table_latch};
        `REG_BANKSEL:       rd_mux = {28'h000_0000, s.bank_select_register};
        `REG_INDEX:         rd_mux = {20'h0_0000, s.idx_base};
        default:      rd_mux = 32'h0000_0000;
      endcase
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[11:10] == `DMEM_PAGE) || (a[11:5] == `HOLD_PAGE) || (a <= `REG_INDEX);
  endfunction

  always_comb
  begin
    logic [20:0] wptr;
    wptr   = s_r.table_pointer;
    s_nxt  = s_r;
    mem_we = 1'b0;
    mem_wa = s_r.addr[7:0];
    mem_wd = s_r.result;

    // apb: answer one cycle after setup, zero wait states
    s_nxt.pready = setup;
    if (setup)
    begin
      s_nxt.prdata  = rd_mux(s_r, paddr, bsy);
      // writes refused while an instruction runs, so core and bus never collide
      s_nxt.pslverr = ~mapped(paddr) | (pwrite & bsy);
    end
    if (commit && pwrite)
    begin
      if (paddr[11:10] == `DMEM_PAGE)
      begin
        mem_we = 1'b1;
        mem_wa = paddr[9:2];
        mem_wd = pwdata[7:0];
      end
      else
        case (paddr)
          `REG_CTRL:
          begin
            s_nxt.ext_en   = pwdata[`CTRL_EXT_BIT];
            s_nxt.two_word = pwdata[`CTRL_TWO_BIT];
          end
          `REG_INSTR:
          begin
            s_nxt.op      = pwdata[15:0];
            s_nxt.state   = core_exec_pkg::ST_EXEC;
            s_nxt.q       = 2'h0;
            s_nxt.skipped = 1'b0;
          end
          `REG_STATUS:
          begin
            s_nxt.neg  = pwdata[`STAT_NEG_BIT];
            s_nxt.zero = pwdata[`STAT_ZERO_BIT];
          end
          `REG_WORK:    s_nxt.wreg   = pwdata[7:0];
          `REG_TABLE_POINTER: s_nxt.table_pointer        = pwdata[20:0]; // RULE_01
          `REG_TABLE_LATCH:   s_nxt.table_latch          = pwdata[7:0];
          `REG_BANKSEL:       s_nxt.bank_select_register = pwdata[3:0];
          `REG_INDEX:         s_nxt.idx_base             = pwdata[11:0];
          default:      s_nxt.ext_en = s_r.ext_en;
        endcase
    end

    case (s_r.state)
      core_exec_pkg::ST_IDLE:
        s_nxt.q = 2'h0;
      core_exec_pkg::ST_EXEC:
      begin
        s_nxt.q = s_r.q + 2'h1;
        if (s_r.q == 2'h0)
          s_nxt.addr = file_addr(s_r.op, s_r.bank_select_register, s_r.idx_base, s_r.ext_en);
        if (s_r.q == `Q_READ)
          s_nxt.operand = dmem[s_r.addr[7:0]]; // RULE_13
        if (s_r.q == `Q_PROC)
          s_nxt.result = x_y;
        if (s_r.q == `Q_LAST)
        begin
          s_nxt.state = core_exec_pkg::ST_IDLE;
          // operands unchanged since q2, so the shared unit still shows the result's flags
          if (is_xor_lit)
          begin
            s_nxt.wreg = s_r.result; // RULE_11
            s_nxt.neg  = x_neg; // RULE_15
            s_nxt.zero = x_zero; // RULE_15
          end
          else if (is_xor_file)
          begin
            if (s_r.op[9])
              mem_we = 1'b1; // RULE_14
            else
              s_nxt.wreg = s_r.result; // RULE_14
            s_nxt.neg  = x_neg; // RULE_15
            s_nxt.zero = x_zero; // RULE_15
          end
          else if (is_tst && s_r.operand == 8'h00)
          begin
            s_nxt.state   = core_exec_pkg::ST_NOP; // RULE_06
            s_nxt.skipped = 1'b1;
            s_nxt.extra   = s_r.two_word ? `EXTRA_TWO : `EXTRA_ONE; // RULE_07
          end
          else if (is_table_write)
          begin
            s_nxt.state = core_exec_pkg::ST_NOP;
            s_nxt.extra = `EXTRA_ONE;
          end
        end
      end
      core_exec_pkg::ST_NOP:
      begin
        s_nxt.q = s_r.q + 2'h1;
        if (s_r.q == `Q_LAST)
        begin
          s_nxt.extra = s_r.extra - 2'h1;
          if (s_r.extra == `EXTRA_ONE)
            s_nxt.state = core_exec_pkg::ST_IDLE;
          // table write lands at the end of its second cycle
          if (is_table_write && s_r.extra == `EXTRA_ONE)
          begin
            case (s_r.op[1:0])
              `TW_PRE_INC:
              begin
                wptr                = s_r.table_pointer + `PTR_ONE; // RULE_04
                s_nxt.table_pointer = wptr;
              end
              `TW_POST_INC: s_nxt.table_pointer = s_r.table_pointer + `PTR_ONE; // RULE_03
              `TW_POST_DEC: s_nxt.table_pointer = s_r.table_pointer - `PTR_ONE;
              default:      s_nxt.table_pointer = s_r.table_pointer;
            endcase
            // holding byte follows wptr bits 2:0, one of eight
            s_nxt.hold[wptr[2:0]] = s_r.table_latch; // RULE_02
          end
        end
      end
      default:
        s_nxt.state = core_exec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '0;
    else if (ce)
      s_r <= s_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (ce && mem_we)
      dmem[mem_wa] <= mem_wd;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      busy <= 1'b0;
    else if (ce)
      busy <= (s_nxt.state != core_exec_pkg::ST_IDLE);
  end

  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign prdata  = s_r.prdata;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic end_q4;
  assign end_q4 = ce && s_r.state == core_exec_pkg::ST_EXEC && s_r.q == `Q_LAST;

  a_xor_lit_result: assert property (end_q4 && is_xor_lit |=> // RULE_11
    s_r.wreg == ($past(s_r.wreg) ^ $past(s_r.op[7:0])))
    else $error("literal xor result wrong");

  a_xor_flags: assert property (end_q4 && (is_xor_lit || is_xor_file) |=> // RULE_16
    s_r.neg == s_r.result[`SIGN_BIT] && s_r.zero == (s_r.result == 8'h00))
    else $error("xor flags wrong");

  a_flags_kept: assert property (end_q4 && (is_tst || is_table_write) && !commit |=> // RULE_15
    $stable(s_r.neg) && $stable(s_r.zero))
    else $error("flags changed by non-xor");

  a_xor_file_dest: assert property (end_q4 && is_xor_file && s_r.op[9] |=> // RULE_14
    dmem[$past(s_r.addr[7:0])] == $past(s_r.result) && $stable(s_r.wreg))
    else $error("file xor destination wrong");

  a_xor_file_read: assert property (ce && s_r.state == core_exec_pkg::ST_EXEC // RULE_13
    && s_r.q == `Q_READ && is_xor_file |=> s_r.operand == dmem[s_r.addr[7:0]])
    else $error("file operand not read in q2");

  sequence skip_start;
    end_q4 && is_tst && s_r.operand == 8'h00;
  endsequence

  a_skip_one: assert property (skip_start ##0 !s_r.two_word |=> // RULE_06
    s_r.state == core_exec_pkg::ST_NOP && s_r.extra == `EXTRA_ONE)
    else $error("skip did not add one nop cycle");

  a_skip_two: assert property (skip_start ##0 s_r.two_word |=> // RULE_07
    s_r.state == core_exec_pkg::ST_NOP && s_r.extra == `EXTRA_TWO)
    else $error("two-word skip did not add two cycles");

  a_no_skip: assert property (end_q4 && is_tst && s_r.operand != 8'h00 |=> // RULE_06
    s_r.state == core_exec_pkg::ST_IDLE)
    else $error("nonzero test skipped");

  a_post_inc: assert property (ce && s_r.state == core_exec_pkg::ST_NOP // RULE_03
    && is_table_write && s_r.q == `Q_LAST && s_r.op[1:0] == `TW_POST_INC |=>
    s_r.table_pointer == $past(s_r.table_pointer) + `PTR_ONE
    && s_r.hold[$past(s_r.table_pointer[2:0])] == $past(s_r.table_latch))
    else $error("post-increment write wrong");

  a_pre_inc: assert property (ce && s_r.state == core_exec_pkg::ST_NOP // RULE_04
    && is_table_write && s_r.q == `Q_LAST && s_r.op[1:0] == `TW_PRE_INC |=>
    s_r.table_pointer == $past(s_r.table_pointer) + `PTR_ONE
    && s_r.hold[s_r.table_pointer[2:0]] == $past(s_r.table_latch))
    else $error("pre-increment write wrong");

  a_bank_addr: assert property (ce && s_r.state == core_exec_pkg::ST_EXEC // RULE_08
    && s_r.q == 2'h0 && s_r.op[8] |=>
    s_r.addr == {$past(s_r.bank_select_register), $past(s_r.op[7:0])})
    else $error("banked address wrong");

endmodule // core_exec
`default_nettype wire

// ### rtl/core_exec_regs.svh
// register offsets, field positions, opcode patterns and decode constants
// assumes a 32-bit apb slave with word-aligned registers
`ifndef CORE_EXEC_REGS_SVH
`define CORE_EXEC_REGS_SVH

`define REG_CTRL        12'h000
`define REG_INSTR       12'h004
`define REG_STATUS      12'h008
`define REG_WORK        12'h00C
`define REG_TABLE_POINTER 12'h010
`define REG_TABLE_LATCH 12'h014
`define REG_BANKSEL     12'h018
`define REG_INDEX       12'h01C
`define HOLD_PAGE       7'h02
`define DMEM_PAGE       2'b01

`define CTRL_EXT_BIT    0
`define CTRL_TWO_BIT    1
`define STAT_BUSY_BIT   0
`define STAT_NEG_BIT    1
`define STAT_ZERO_BIT   2
`define STAT_SKIP_BIT   3

`define OPC_XOR_LIT     8'h0A
`define OPC_XOR_FILE    6'h06
`define OPC_TEST_SKIP   7'h33
`define OPC_TABLE_WRITE 14'h0003
`define TW_NONE         2'h0
`define TW_POST_INC     2'h1
`define TW_POST_DEC     2'h2
`define TW_PRE_INC      2'h3

`define ACC_SPLIT       8'h60
`define EXT_LIMIT       8'h5F
`define ACC_HIGH_BANK   4'hF
`define ACC_LOW_BANK    4'h0
`define Q_LAST          2'h3
`define Q_READ          2'h1
`define Q_PROC          2'h2
`define EXTRA_ONE       2'h1
`define EXTRA_TWO       2'h2
`define PTR_ONE         21'h00_0001
`define SIGN_BIT        7

`endif

// ### rtl/core_exec_pkg.sv
// types shared by the instruction execute block
// assumes core_exec_regs.svh supplies the numeric constants
`default_nettype none
package core_exec_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOP  = 2'b10
  } exec_state_t;

  typedef struct packed {
    exec_state_t     state;
    logic [1:0]      q;
    logic [1:0]      extra;
    logic [15:0]     op;
    logic [7:0]      wreg;
    logic            neg;
    logic            zero;
    logic            skipped;
    logic [20:0]     table_pointer;
    logic [7:0]      table_latch;
    logic [3:0]      bank_select_register;
    logic [11:0]     idx_base;
    logic            ext_en;
    logic            two_word;
    logic [7:0][7:0] hold;
    logic [7:0]      operand;
    logic [7:0]      result;
    logic [11:0]     addr;
    logic            pready;
    logic            pslverr;
    logic [31:0]     prdata;
  } exec_regs_t;

endpackage
`default_nettype wire

// ### rtl/xor_flag_unit.sv
// xor of two bytes with negative and zero flags
// assumes purely combinational use by the execute block
`timescale 1ns/10ps
`default_nettype none
`include "core_exec_regs.svh"

module xor_flag_unit
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  output logic      [7:0] y,
  output logic            neg,
  output logic            zero
);

  assign y    = a ^ b;
  assign neg  = y[`SIGN_BIT]; // RULE_16
  assign zero = (y == 8'h00); // RULE_16

endmodule // xor_flag_unit
`default_nettype wire

// ### test/tb.sv
// self-checking bench for core_exec: xor forms, test-skip-zero, table write
// assumes the exec package, core_exec.sv and core_exec_regs.svh are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "core_exec_regs.svh"

module tb;
  typedef struct {
    logic [1:0]  ctrl;
    logic [15:0] op;
    logic [7:0]  w0;
    logic [7:0]  f0;
    logic [7:0]  mi;
    logic [7:0]  w1;
    logic [7:0]  f1;
    logic [3:0]  s0;
    logic [3:0]  st;
    int          cyc;
  } row_t;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        busy;
  logic [31:0] rd;
  logic        er;
  int          nb;
  int          err_count = 0;
  int          checked = 0;

  // bank select 5, index base 0x123: indexed offsets land at 0x23 + f
  row_t rows [11] = '{
    '{2'h0, 16'h0aaf, 8'hb5, 8'h77, 8'h10, 8'h1a, 8'h77, 4'h6, 4'h0, 4},
    '{2'h0, 16'h0a80, 8'h00, 8'h77, 8'h10, 8'h80, 8'h77, 4'h4, 4'h2, 4},
    '{2'h0, 16'h0a55, 8'h55, 8'h77, 8'h10, 8'h00, 8'h77, 4'h2, 4'h4, 4},
    '{2'h0, 16'h1a20, 8'hb5, 8'haf, 8'h20, 8'hb5, 8'h1a, 4'h6, 4'h0, 4},
    '{2'h0, 16'h1921, 8'h0f, 8'hf0, 8'h21, 8'hff, 8'hf0, 4'h0, 4'h2, 4},
    '{2'h1, 16'h1a10, 8'h3c, 8'h3c, 8'h33, 8'h3c, 8'h00, 4'h2, 4'h4, 4},
    '{2'h1, 16'h1a60, 8'h01, 8'h81, 8'h60, 8'h01, 8'h80, 4'h4, 4'h2, 4},
    '{2'h0, 16'h6630, 8'h99, 8'h01, 8'h30, 8'h99, 8'h01, 4'h6, 4'h6, 4},
    '{2'h0, 16'h6731, 8'h99, 8'h00, 8'h31, 8'h99, 8'h00, 4'h2, 4'ha, 8},
    '{2'h2, 16'h6632, 8'h99, 8'h00, 8'h32, 8'h99, 8'h00, 4'h6, 4'he, 12},
    '{2'h1, 16'h6605, 8'h99, 8'h00, 8'h28, 8'h99, 8'h00, 4'h0, 4'h8, 8}
  };

  core_exec dut
  (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .pslverr (pslverr),
    .prdata  (prdata),
    .busy    (busy)
  );

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("errors %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  // entered just after a rising edge; leaves one idle edge so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_count++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic wait_idle();
    nb = 0;
    while (busy === 1'b1 && nb < 40)
    begin
      nb++;
      @(posedge clk);
    end
    if (busy !== 1'b0)
    begin
      err_count++;
      end_sim();
    end
  endtask

  task automatic run(input logic [15:0] op, input int cyc);
    wr(`REG_INSTR, {16'h0, op});
    wait_idle();
    chk("cycles", cyc, nb);
  endtask

  function automatic logic [11:0] maddr(input logic [7:0] i);
    return 12'h400 + {2'b00, i, 2'b00};
  endfunction

  task automatic tw(input logic [1:0] m, input logic [20:0] p, input logic [7:0] l,
                    input logic [20:0] pe, input logic [2:0] ix);
    wr(12'h010, {11'h0, p});
    wr(12'h014, {24'h0, l});
    run({`OPC_TABLE_WRITE, m}, 8);
    rdchk(12'h010, {11'h0, pe}, "pointer");
    rdchk(12'h040 + {7'h0, ix, 2'b00}, {24'h0, l}, "holding");
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wr(`REG_BANKSEL, 32'h0000_0005);
    wr(`REG_INDEX, 32'h0000_0123);
    foreach (rows[i])
    begin
      wr(`REG_CTRL, {30'h0, rows[i].ctrl});
      wr(`REG_STATUS, {28'h0, rows[i].s0});
      wr(`REG_WORK, {24'h0, rows[i].w0});
      // direct address filled nonzero so a wrong bank mode shows
      wr(maddr(rows[i].op[7:0]), 32'h0000_00ff);
      wr(maddr(rows[i].mi), {24'h0, rows[i].f0});
      run(rows[i].op, rows[i].cyc);
      rdchk(`REG_WORK, {24'h0, rows[i].w1}, "work");
      rdchk(maddr(rows[i].mi), {24'h0, rows[i].f1}, "file");
      rdchk(`REG_STATUS, {28'h0, rows[i].st}, "status");
    end
    // a write while executing is refused and leaves the working register alone
    wr(`REG_WORK, 32'h0000_000f);
    apb(1'b1, `REG_INSTR, 32'h0000_0aff);
    apb(1'b1, `REG_WORK, 32'h0000_0011);
    chk("busy refusal", 32'h1, {31'h0, er});
    wait_idle();
    rdchk(`REG_WORK, 32'h0000_00f0, "work after refusal");
    // ce low for three edges must stretch the instruction by three cycles
    wr(`REG_INSTR, 32'h0000_0a0f);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    wait_idle();
    chk("frozen cycles", 32'h0000_0004, nb);
    rdchk(`REG_WORK, 32'h0000_00ff, "work after freeze");
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(`REG_WORK, 32'h0, "work reset");
    rdchk(`REG_STATUS, 32'h0, "status reset");
    rdchk(12'h010, 32'h0, "pointer reset");
    wr(`REG_STATUS, 32'h0000_0006);
    tw(2'h1, 21'h00_a356, 8'h55, 21'h00_a357, 3'h6);
    tw(2'h3, 21'h01_389a, 8'h34, 21'h01_389b, 3'h3);
    rdchk(12'h048, 32'h0, "holding untouched");
    tw(2'h2, 21'h00_0010, 8'ha5, 21'h00_000f, 3'h0);
    tw(2'h0, 21'h00_0011, 8'h5a, 21'h00_0011, 3'h1);
    tw(2'h1, 21'h1f_ffff, 8'h77, 21'h00_0000, 3'h7);
    rdchk(`REG_STATUS, 32'h0000_0006, "status kept");
    end_sim();
  end
endmodule // tb

`default_nettype wire
